//--- design/duad_params.svh
// Purpose: Constants for the dual serial board address decoder
// Assumes: 100 MHz system clock, 10-bit host I/O address
// Notes:   Offsets are byte offsets inside the 32-location window
`ifndef DUAD_PARAMS_SVH
`define DUAD_PARAMS_SVH

`define DUAD_ADDR_W            10
`define DUAD_WIN_LSB           5
`define DUAD_OFF_W             5
`define DUAD_OFF_PORT_B        5'h08
`define DUAD_OFF_IRQ_STATUS    5'h10
`define DUAD_REG_DIV_LOW       3'h0
`define DUAD_REG_DIV_HIGH      3'h1
`define DUAD_REG_INT_ENABLE    3'h1
`define DUAD_REG_INT_ID        3'h2
`define DUAD_REG_LINE_CTRL     3'h3
`define DUAD_REG_MODEM_CTRL    3'h4
`define DUAD_REG_LINE_STATUS   3'h5
`define DUAD_REG_MODEM_STATUS  3'h6
`define DUAD_REG_SCRATCH       3'h7
`define DUAD_DIV_LATCH_BIT     7
`define DUAD_LCR_RESET         8'h00
`define DUAD_DIV_RESET         16'h000C
`define DUAD_OVERSAMPLE        32
`define DUAD_SYS_CLK_HZ        100000000
`define DUAD_REF_CLK_HZ        1843200
`define DUAD_IIR_NONE          8'h01
`define DUAD_IIR_THR_EMPTY     8'h02
`define DUAD_IIR_RX_AVAIL      8'h04
`define DUAD_LSR_IDLE          8'h60
`define DUAD_IRQ_LINES         13

`endif

//--- design/duad_pkg.sv
// Purpose: Types for the dual serial board address decoder
// Assumes: Included constants header is on the include path
// Notes:   Holds per-port state and whole-block state structs
`include "duad_params.svh"

package duad_pkg;

    // Register state of one serial port
    typedef struct packed {
        logic [7:0]  line_control;
        logic [15:0] baud_divisor;
        logic [7:0]  int_enable;
        logic [7:0]  modem_control;
        logic [7:0]  scratch;
        logic [7:0]  rx_data;
        logic        rx_ready;
        logic        tx_empty;
        logic [15:0] tick_count;
        logic [4:0]  bit_phase;
        logic        baud_tick;
    } duad_port_t;

    // Whole block state
    typedef struct packed {
        duad_port_t [1:0] port;
        logic [7:0]       read_data;
        logic [1:0]       cs;
        logic             status_cs;
        logic [12:0]      irq;
        logic [1:0]       baud_tick;
        logic [31:0]      ref_acc;
    } duad_state_t;

endpackage

//--- design/duad_decoder.sv
// Purpose: Host I/O bus decoder and register set for a two-port serial board
// Assumes: Bus strobes are synchronous to clk_in; jumpers are static
// Notes:   Serial framing is outside; each port exposes a tick and data handoff
`timescale 1ns/1ps
`default_nettype none

module duad_decoder
    import duad_pkg::*;
#(
    parameter int REF_CLK_HZ = `DUAD_REF_CLK_HZ,
    parameter int SYS_CLK_HZ = `DUAD_SYS_CLK_HZ
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [`DUAD_ADDR_W-1:0] addr_in,
    input  wire logic                    addr_high_zero_in,
    input  wire logic                    io_read_in,
    input  wire logic                    io_write_in,
    input  wire logic [7:0]              write_data_in,
    input  wire logic [4:0]              base_address_jumpers_in,
    input  wire logic [3:0]              host_interrupt_line_choice_in,
    input  wire logic [1:0]              rx_strobe_in,
    input  wire logic [15:0]             rx_byte_in,
    input  wire logic [1:0]              tx_done_in,
    output logic      [7:0]              read_data_out,
    output logic      [1:0]              port_select_out,
    output logic                         status_select_out,
    output logic      [12:0]             host_irq_out,
    output logic      [1:0]              baud_tick_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: every outside pin except rst_in passes two flops before use
    logic [2*(`DUAD_ADDR_W+1+2+8+5+4+2+16+2)-1:0] sync_q;
    logic [`DUAD_ADDR_W-1:0] addr;
    logic                    high_zero, rd, wr;
    logic [7:0]              wdata;
    logic [4:0]              jumpers;
    logic [3:0]              irq_choice;
    logic [1:0]              rx_stb, tx_done;
    logic [15:0]             rx_byte;
    localparam int SW = `DUAD_ADDR_W + 1 + 2 + 8 + 5 + 4 + 2 + 16 + 2;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        sync_q <= {sync_q[SW-1:0],
                   addr_in, addr_high_zero_in, io_read_in, io_write_in, write_data_in,
                   base_address_jumpers_in, host_interrupt_line_choice_in,
                   rx_strobe_in, rx_byte_in, tx_done_in};
    end

    assign {addr, high_zero, rd, wr, wdata, jumpers, irq_choice,
            rx_stb, rx_byte, tx_done} = sync_q[2*SW-1:SW];

    ////////////////////////////////////////////////////////////////////////////
    // Edge detect on strobes so a held strobe acts once
    logic [1:0] strobe_prev;
    logic [1:0] rx_prev;
    logic       rd_edge, wr_edge;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strobe_prev <= 2'h0;
            rx_prev     <= 2'h0;
        end else begin
            strobe_prev <= {rd, wr};
            rx_prev     <= rx_stb;
        end
    end

    assign rd_edge = rd & ~strobe_prev[1];
    assign wr_edge = wr & ~strobe_prev[0];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt identification for one port, received data (code 04) wins over transmit empty (code 02)
    function automatic logic [7:0] int_ident(input duad_port_t p);
        if (p.int_enable[0] && p.rx_ready) begin
            int_ident = `DUAD_IIR_RX_AVAIL;
        end else if (p.int_enable[1] && p.tx_empty) begin
            int_ident = `DUAD_IIR_THR_EMPTY;
        end else begin
            int_ident = `DUAD_IIR_NONE;
        end
    endfunction

    // Port requests service when an identified cause exists and output gate is open
    function automatic logic port_irq(input duad_port_t p);
        logic [7:0] ident;
        ident    = int_ident(p);
        port_irq = ~ident[0] & p.modem_control[3];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Block state, one struct registered as a whole
    duad_state_t st, next_st;
    logic        board_hit;
    logic [4:0]  offset;
    logic        sel_b;
    logic        div_access;
    logic [2:0]  reg_idx;
    logic [31:0] next_acc;

    always_comb begin
        next_st = st;
        // Jumper on reads zero, off reads one, each on its own line
        board_hit = high_zero && (addr[`DUAD_ADDR_W-1:`DUAD_WIN_LSB] == jumpers);
        offset    = addr[`DUAD_OFF_W-1:0];
        sel_b     = offset[3];
        reg_idx   = offset[2:0];
        div_access = st.port[sel_b].line_control[`DUAD_DIV_LATCH_BIT];
        next_st.cs        = 2'h0;
        next_st.status_cs = 1'b0;
        next_st.baud_tick = 2'h0;

        // Shared reference clock from a phase accumulator; fixed rate for both ports
        next_acc = st.ref_acc + 32'(REF_CLK_HZ);
        if (next_acc >= 32'(SYS_CLK_HZ)) begin
            next_acc = next_acc - 32'(SYS_CLK_HZ);
        end
        next_st.ref_acc = next_acc;

        // Per-port divider: 32 reference edges times divisor per bit
        for (int i = 0; i < 2; i++) begin
            if (st.ref_acc + 32'(REF_CLK_HZ) >= 32'(SYS_CLK_HZ)) begin
                if (st.port[i].tick_count + 16'h0001 >= st.port[i].baud_divisor) begin
                    next_st.port[i].tick_count = 16'h0000;
                    next_st.port[i].bit_phase  = st.port[i].bit_phase + 5'h01;
                    if (st.port[i].bit_phase == 5'(`DUAD_OVERSAMPLE - 1)) begin
                        next_st.baud_tick[i] = 1'b1;
                    end
                end else begin
                    next_st.port[i].tick_count = st.port[i].tick_count + 16'h0001;
                end
            end
        end

        // Bus access, only inside the claimed window and on a valid strobe
        if (board_hit && (rd_edge || wr_edge)) begin
            if (!offset[4]) begin
                next_st.cs[sel_b] = 1'b1;
            end else if (offset == `DUAD_OFF_IRQ_STATUS && rd_edge) begin
                next_st.status_cs = 1'b1;
            end
        end

        if (board_hit && wr_edge && !offset[4]) begin
            unique case (reg_idx)
                `DUAD_REG_DIV_LOW: begin
                    if (div_access) begin
                        next_st.port[sel_b].baud_divisor[7:0] = wdata;
                    end else begin
                        next_st.port[sel_b].tx_empty = 1'b0;
                    end
                end
                `DUAD_REG_DIV_HIGH: begin
                    if (div_access) begin
                        next_st.port[sel_b].baud_divisor[15:8] = wdata;
                    end else begin
                        next_st.port[sel_b].int_enable = {4'h0, wdata[3:0]};
                    end
                end
                `DUAD_REG_LINE_CTRL:   next_st.port[sel_b].line_control  = wdata;
                `DUAD_REG_MODEM_CTRL:  next_st.port[sel_b].modem_control = {3'h0, wdata[4:0]};
                `DUAD_REG_SCRATCH:     next_st.port[sel_b].scratch       = wdata;
                default: ;
            endcase
        end

        // Read data path; unused offsets read zero and writes there are dropped
        if (board_hit && rd_edge) begin
            next_st.read_data = 8'h00;
            if (offset == `DUAD_OFF_IRQ_STATUS) begin
                next_st.read_data = {6'h00, port_irq(st.port[1]), port_irq(st.port[0])};
            end else if (!offset[4]) begin
                unique case (reg_idx)
                    `DUAD_REG_DIV_LOW: begin
                        if (div_access) begin
                            next_st.read_data = st.port[sel_b].baud_divisor[7:0];
                        end else begin
                            next_st.read_data = st.port[sel_b].rx_data;
                            next_st.port[sel_b].rx_ready = 1'b0;
                        end
                    end
                    `DUAD_REG_DIV_HIGH: begin
                        next_st.read_data = div_access ? st.port[sel_b].baud_divisor[15:8]
                                                       : st.port[sel_b].int_enable;
                    end
                    `DUAD_REG_INT_ID:      next_st.read_data = int_ident(st.port[sel_b]);
                    `DUAD_REG_LINE_CTRL:   next_st.read_data = st.port[sel_b].line_control;
                    `DUAD_REG_MODEM_CTRL:  next_st.read_data = st.port[sel_b].modem_control;
                    `DUAD_REG_LINE_STATUS: begin
                        next_st.read_data = {1'b0, st.port[sel_b].tx_empty, st.port[sel_b].tx_empty,
                                             4'h0, st.port[sel_b].rx_ready};
                    end
                    `DUAD_REG_MODEM_STATUS: next_st.read_data = 8'h00;
                    `DUAD_REG_SCRATCH:      next_st.read_data = st.port[sel_b].scratch;
                    default: ;
                endcase
            end
        end

        // Received byte arrival wins over a clearing read in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (rx_stb[i] && !rx_prev[i]) begin
                next_st.port[i].rx_data  = rx_byte[8*i +: 8];
                next_st.port[i].rx_ready = 1'b1;
            end
            // Transmit done wins over a clearing write in the same cycle
            if (tx_done[i]) begin
                next_st.port[i].tx_empty = 1'b1;
            end
        end

        // Shared request onto the one line the jumper picks
        next_st.irq = 13'h0000;
        if ((port_irq(st.port[0]) || port_irq(st.port[1])) &&
            irq_choice < 4'(`DUAD_IRQ_LINES)) begin
            next_st.irq[irq_choice] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
            for (int i = 0; i < 2; i++) begin
                st.port[i].line_control <= `DUAD_LCR_RESET;
                st.port[i].baud_divisor <= `DUAD_DIV_RESET;
                st.port[i].tx_empty     <= 1'b1;
            end
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from state flops
    assign read_data_out     = st.read_data;
    assign port_select_out   = st.cs;
    assign status_select_out = st.status_cs;
    assign host_irq_out      = st.irq;
    assign baud_tick_out     = st.baud_tick;

endmodule // duad_decoder

`default_nettype wire

//--- tb/duad_decoder_asserts.sv
// Purpose: Bus-side checks for the dual serial board decoder
// Assumes: Strobes pass two sync flops before decode
// Notes:   Answers land one or two edges after the synced rise
`timescale 1ns/1ps
`default_nettype none
module duad_decoder_asserts (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [9:0]  addr_in,
    input wire logic        addr_high_zero_in,
    input wire logic        io_read_in,
    input wire logic        io_write_in,
    input wire logic [4:0]  base_address_jumpers_in,
    input wire logic [3:0]  host_interrupt_line_choice_in,
    input wire logic [7:0]  read_data_out,
    input wire logic [1:0]  port_select_out,
    input wire logic        status_select_out,
    input wire logic [12:0] host_irq_out
);
    logic [2:0] rq;
    logic [2:0] wq;
    logic       rd_go;
    logic       acc;
    logic       hit;
    // Mirror of the sync chain, so strobe edges line up with the decode
    always_ff @(posedge clk_in) begin
        rq <= rst_in ? 3'h0 : {rq[1:0], io_read_in};
        wq <= rst_in ? 3'h0 : {wq[1:0], io_write_in};
    end
    assign rd_go = rq[1] & ~rq[2];
    assign acc   = rd_go | (wq[1] & ~wq[2]);
    assign hit   = addr_high_zero_in && (addr_in[9:5] == base_address_jumpers_in);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_sel_a; acc && hit && addr_in[4:3] == 2'b00 |-> ##[1:2] port_select_out == 2'b01; endproperty
    a_sel_a: assert property (p_sel_a) else $error("port A select missing");
    property p_sel_b; acc && hit && addr_in[4:3] == 2'b01 |-> ##[1:2] port_select_out == 2'b10; endproperty
    a_sel_b: assert property (p_sel_b) else $error("port B select missing");
    property p_no_sel; acc && !(hit && !addr_in[4]) |-> ##1 port_select_out == 2'b00 ##1 port_select_out == 2'b00;
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("port select outside its range");
    property p_st; rd_go && hit && addr_in[4:0] == 5'h10 |-> ##[1:2] status_select_out; endproperty
    a_st: assert property (p_st) else $error("status select missing");
    property p_no_st; acc && !(rd_go && hit && addr_in[4:0] == 5'h10) |-> ##1 !status_select_out ##1 !status_select_out;
    endproperty
    a_no_st: assert property (p_no_st) else $error("status select on wrong access");
    property p_pulse; port_select_out != 2'b00 || status_select_out |=> port_select_out == 2'b00 && !status_select_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("select longer than one cycle");
    property p_onehot; $onehot0(host_irq_out); endproperty
    a_onehot: assert property (p_onehot) else $error("more than one host line driven");
    // Choice passes two sync flops and the output register, so look three edges back
    property p_line; host_irq_out != 13'h0 |-> host_irq_out == 13'h1 << $past(host_interrupt_line_choice_in, 3);
    endproperty
    a_line: assert property (p_line) else $error("host line not the chosen one");
    property p_none; $past(host_interrupt_line_choice_in, 3) > 4'd12 |-> host_irq_out == 13'h0; endproperty
    a_none: assert property (p_none) else $error("line driven with no valid choice");
    // Read data only moves in the wake of a read that hits the window
    property p_hold; !$past(rd_go && hit, 1) && !$past(rd_go && hit, 2) |-> $stable(read_data_out); endproperty
    a_hold: assert property (p_hold) else $error("read data changed without a read");
    c_port_b: cover property (acc && hit && addr_in[4:3] == 2'b01);
    c_status: cover property (rd_go && hit && addr_in[4:0] == 5'h10);
    c_irq: cover property (host_irq_out != 13'h0);
endmodule // duad_decoder_asserts
////////////////////////////////////////////////////////////////////////////////
bind duad_decoder duad_decoder_asserts u_duad_decoder_asserts (.clk_in, .rst_in, .addr_in, .addr_high_zero_in,
    .io_read_in, .io_write_in, .base_address_jumpers_in, .host_interrupt_line_choice_in, .read_data_out,
    .port_select_out, .status_select_out, .host_irq_out);
`default_nettype wire

//--- tb/duad_host_model.sv
// Purpose: Host processor driving I/O cycles on the expansion bus
// Assumes: No ready line; the answer is taken after a fixed hold
// Notes:   Idle bus shows the inverse of the last cycle
`timescale 1ns/1ps
`default_nettype none
module duad_host_model (
    input  wire logic       clk_in,
    output logic      [9:0] addr_out,
    output logic            high_zero_out,
    output logic            rd_out,
    output logic            wr_out,
    output logic      [7:0] data_out,
    input  wire logic [7:0] rdata_in
);
    initial begin
        {addr_out, high_zero_out, rd_out, wr_out, data_out} = {10'h3ff, 1'b0, 2'b00, 8'hff};
    end
    // Hold six edges, past the three-edge answer, then keep the strobe low three
    task automatic io(input logic w, input logic [9:0] a, input logic hz, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        {addr_out, high_zero_out, data_out} <= {a, hz, d};
        {wr_out, rd_out} <= {w, !w};
        repeat (6) @(posedge clk_in);
        q = rdata_in;
        // Released lines flip, so a stale address can never match by luck
        {addr_out, high_zero_out, data_out, rd_out, wr_out} <= {~a, ~hz, ~d, 2'b00};
        repeat (3) @(posedge clk_in);
    endtask
endmodule // duad_host_model
`default_nettype wire

//--- tb/duad_decoder_tb.sv
// Purpose: Self-checking bench for the dual serial board decoder
// Assumes: Reference clock set to a quarter of the system clock
// Notes:   One bit time is then 128 clocks per divisor step
`timescale 1ns/1ps
`default_nettype none
module duad_decoder_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [9:0]  addr;
    logic        hz, rd, wr, ssel;
    logic [7:0]  wd, rdat, q, v, dv;
    logic [4:0]  jmp = 5'h00, o;
    logic [3:0]  irq_sel = 4'h0;
    logic [1:0]  rxs = 2'b00, psel, tick;
    logic [15:0] rxb = 16'h0000;
    logic [12:0] irq;
    int          errors = 0, n_tests = 0, cnt;
    always #5 clk_in = ~clk_in;
    duad_host_model u_duad_host_model (.clk_in(clk_in), .addr_out(addr), .high_zero_out(hz), .rd_out(rd),
        .wr_out(wr), .data_out(wd), .rdata_in(rdat));
    duad_decoder #(.REF_CLK_HZ(32'h017D_7840)) u_duad_decoder (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .addr_high_zero_in(hz), .io_read_in(rd), .io_write_in(wr), .write_data_in(wd),
        .base_address_jumpers_in(jmp), .host_interrupt_line_choice_in(irq_sel), .rx_strobe_in(rxs),
        .rx_byte_in(rxb), .tx_done_in(2'b00), .read_data_out(rdat), .port_select_out(psel),
        .status_select_out(ssel), .host_irq_out(irq), .baud_tick_out(tick));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        u_duad_host_model.io(1'b1, {jmp, a}, 1'b1, d, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string nm);
        u_duad_host_model.io(1'b0, {jmp, a}, 1'b1, 8'h00, q);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask
    // Gap between the second and third tick, so a divisor change settles
    task automatic tick_gap(input int p, output int c);
        repeat (3) begin
            c = 0;
            do begin
                @(posedge clk_in);
                c++;
            end while (tick[p] !== 1'b1 && c < 2000);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd554_c54b));
        jmp <= 5'($urandom);
        irq_sel <= 4'($urandom_range(12));
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rdc(5'h02, 8'h01, "ident_a");
        rdc(5'h0d, 8'h60, "line_status_b");
        wr8(5'h10, 8'hff);
        rdc(5'h10, 8'h00, "irq_status");
        rdc(5'h11 + 5'($urandom_range(14)), 8'h00, "unused");
        v = 8'($urandom);
        wr8(5'h07, v);
        wr8(5'h0f, ~v);
        // Near misses: each jumper bit alone, and a nonzero upper address
        for (int k = 0; k < 5; k++) u_duad_host_model.io(1'b1, {jmp ^ 5'(1 << k), 5'h07}, 1'b1, 8'h5a, q);
        u_duad_host_model.io(1'b1, {jmp, 5'h07}, 1'b0, 8'h5a, q);
        rdc(5'h07, v, "scratch_a");
        rdc(5'h0f, ~v, "scratch_b");
        for (int p = 0; p < 2; p++) begin
            o = 5'(p * 8);
            dv = 8'($urandom_range(4, 1));
            wr8(o + 5'h3, 8'h80);
            rdc(o, 8'h0c, "div_low_reset");
            rdc(o + 5'h1, 8'h00, "div_high_reset");
            wr8(o, dv);
            wr8(o + 5'h1, 8'h00);
            rdc(o, dv, "div_low");
            wr8(o + 5'h3, 8'h03);
            wr8(o + 5'h1, 8'h01);
            rdc(o + 5'h1, 8'h01, "int_enable");
            tick_gap(p, cnt);
            chk("bit_time", 16'(128 * dv), 16'(cnt));
            wr8(o + 5'h4, 8'h08);
            v = 8'($urandom);
            rxb[p*8 +: 8] <= v;
            rxs[p] <= 1'b1;
            repeat (2) @(posedge clk_in);
            rxs[p] <= 1'b0;
            cnt = 0;
            while (irq === 13'h0 && cnt < 20) begin
                @(posedge clk_in);
                cnt++;
            end
            chk("host_irq", 16'(13'h1 << irq_sel), {3'h0, irq});
            rdc(5'h10, 8'(1 << p), "irq_status");
            if (p == 1) begin
                irq_sel <= 4'hd;
                repeat (4) @(posedge clk_in);
                chk("irq_none", 16'h0000, {3'h0, irq});
            end
            rdc(o, v, "rx_data");
            chk("irq_clear", 16'h0000, {3'h0, irq});
        end
        finish_test();
    end
    // Whole run needs a few thousand cycles; this limit only catches a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        finish_test();
    end
endmodule // duad_decoder_tb
`default_nettype wire
